// ===== hdl/ee_spi_cfg.svh
// Constants for the serial EEPROM pin interface
`ifndef EE_SPI_CFG_SVH
`define EE_SPI_CFG_SVH

`define EE_OP_WREN 8'h06
`define EE_OP_WRDI 8'h04
`define EE_OP_READ_STATUS 8'h05
`define EE_OP_WRSR 8'h01
`define EE_OP_READ 8'h03
`define EE_OP_WRITE 8'h02

`define EE_STAT_PPE_BIT 7
`define EE_STAT_BP_HI 3
`define EE_STAT_BP_LO 2
`define EE_STAT_WEL_BIT 1
`define EE_STAT_BUSY_BIT 0

`define EE_CLK_PERIOD_NS 25
`define EE_PROGRAMMING_CYCLE_TIME_MS 5
`define EE_PROG_CYCLES \
  (`EE_PROGRAMMING_CYCLE_TIME_MS * 1000000 / `EE_CLK_PERIOD_NS)
`define EE_POWER_UP_READ_WAIT_MS 1
`define EE_POWER_UP_WRITE_WAIT_MS 1

`define EE_PROG_W 18
`define EE_PAGE_LO_W 7
`define EE_PIN_RESET 5'h0b
`define EE_LAST_BIT 3'h7
`define EE_FIRST_BIT 3'h0

`endif

// ===== hdl/ee_spi_pkg.sv
// Types shared by the serial EEPROM pin interface
package ee_spi_pkg;

  typedef struct packed {
    logic sck;
    logic cs_n;
    logic si;
    logic hold_n;
    logic wp_n;
  } pins_s;

  typedef struct packed {
    logic wr;
    logic [15:0] addr;
    logic [7:0] data;
  } mem_req_s;

  typedef enum logic [2:0] {
    st_op,
    st_addr,
    st_wr_data,
    st_rd_data,
    st_stat_in,
    st_stat_out,
    st_ignore
  } seq_e;

endpackage

// ===== hdl/ee_pin_sync.sv
// Three-stage pin synchroniser with agreement filter, one lane per bit
module ee_pin_sync #(
  parameter int unsigned W = 5,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [W-1:0] pin,
  output logic [W-1:0] stable
);

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_lane
      logic s1_q;
      logic s2_q;
      logic s3_q;
      logic st_q;
      logic st_d;
      // Second and third stages must agree before the level is accepted
      always_comb begin
        st_d = (s2_q == s3_q) ? s2_q : st_q;
      end
      always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
          s1_q <= RESET_VAL[i];
          s2_q <= RESET_VAL[i];
          s3_q <= RESET_VAL[i];
          st_q <= RESET_VAL[i];
        end else begin
          s1_q <= pin[i];
          s2_q <= s1_q;
          s3_q <= s2_q;
          st_q <= st_d;
        end
      end
      assign stable[i] = st_q;
    end
  endgenerate

endmodule

// ===== hdl/ee_spi_pins.sv
// Serial EEPROM pin interface: shift, framing, pause, protect, write timer
`include "ee_spi_cfg.svh"

// Behaviour
// - Sample SI on rising serial clock
// - Change SO on falling serial clock
// - Serial clock only input, times all shifting
// - CS high: SO released, standby after write
// - CS falling/rising edges bound each session
// - Protect pin high never blocks writes
// - Pin low and enable bit set: reject status writes
// - Paused: shift state frozen, clock ignored
// - Paused: SO released, driven again afterward
// - Valid write then CS rise starts timed cycle
// - Enable bit gates the protect pin
// - Busy: only read status accepted, shows busy
module ee_spi_pins #(
  parameter int unsigned PROG_CYCLES = `EE_PROG_CYCLES
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  input wire logic hold_n,
  input wire logic wp_n,
  input wire logic [7:0] rd_data,
  output logic so,
  output logic so_oe_n,
  output ee_spi_pkg::mem_req_s mem_req,
  output logic busy
);

  ee_spi_pkg::pins_s pins_raw;
  ee_spi_pkg::pins_s pins_s;
  logic [4:0] pins_st;

  assign pins_raw = '{sck: sck, cs_n: cs_n, si: si, hold_n: hold_n,
                      wp_n: wp_n};

  ee_pin_sync #(.W(5), .RESET_VAL(`EE_PIN_RESET)) u_sync (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .pin(pins_raw),
    .stable(pins_st)
  );
  assign pins_s = pins_st;

  ee_spi_pkg::seq_e state_q, state_d;
  logic sck_prev_q, sck_prev_d;
  logic cs_prev_q, cs_prev_d;
  logic [2:0] bit_q, bit_d;
  logic [6:0] rx_q, rx_d;
  logic [7:0] tx_q, tx_d;
  logic addr_cnt_q, addr_cnt_d;
  logic op_wr_q, op_wr_d;
  logic [15:0] addr_q, addr_d;
  logic wel_q, wel_d;
  logic ppe_q, ppe_d;
  logic [1:0] bp_q, bp_d;
  logic [7:0] stat_new_q, stat_new_d;
  logic pend_stat_q, pend_stat_d;
  logic pend_prog_q, pend_prog_d;
  logic [`EE_PROG_W-1:0] prog_cnt_q, prog_cnt_d;
  ee_spi_pkg::mem_req_s req_q, req_d;

  logic active;
  logic rise_act;
  logic fall_act;
  logic cs_rise;
  logic byte_done;
  logic [7:0] rx_byte;
  logic [7:0] stat_byte;
  logic hw_protect;
  logic out_state;

  // Clock edges are only seen in the core domain; the pin is never driven
  assign active = !pins_s.cs_n && pins_s.hold_n;
  assign rise_act = active && pins_s.sck && !sck_prev_q;
  assign fall_act = active && !pins_s.sck && sck_prev_q;
  assign cs_rise = pins_s.cs_n && !cs_prev_q;
  assign byte_done = rise_act && (bit_q == `EE_LAST_BIT);
  assign rx_byte = {rx_q, pins_s.si};
  assign busy = (prog_cnt_q != '0);
  assign hw_protect = ppe_q && !pins_s.wp_n;
  assign out_state = (state_q == ee_spi_pkg::st_rd_data) ||
                     (state_q == ee_spi_pkg::st_stat_out);

  always_comb begin
    stat_byte = 8'h00;
    stat_byte[`EE_STAT_PPE_BIT] = ppe_q;
    stat_byte[`EE_STAT_BP_HI:`EE_STAT_BP_LO] = bp_q;
    stat_byte[`EE_STAT_WEL_BIT] = wel_q;
    stat_byte[`EE_STAT_BUSY_BIT] = busy;
  end

  always_comb begin
    state_d = state_q;
    sck_prev_d = pins_s.sck;
    cs_prev_d = pins_s.cs_n;
    bit_d = bit_q;
    rx_d = rx_q;
    tx_d = tx_q;
    addr_cnt_d = addr_cnt_q;
    op_wr_d = op_wr_q;
    addr_d = addr_q;
    wel_d = wel_q;
    ppe_d = ppe_q;
    bp_d = bp_q;
    stat_new_d = stat_new_q;
    pend_stat_d = pend_stat_q;
    pend_prog_d = pend_prog_q;
    prog_cnt_d = busy ? prog_cnt_q - 1'b1 : prog_cnt_q;
    req_d = req_q;
    req_d.wr = 1'b0;
    if (pins_s.cs_n) begin
      // Session closed: back to opcode phase, standby unless programming
      state_d = ee_spi_pkg::st_op;
      bit_d = `EE_FIRST_BIT;
      if (cs_rise && pend_prog_q) begin
        prog_cnt_d = `EE_PROG_W'(PROG_CYCLES);
        wel_d = 1'b0;
        if (pend_stat_q) begin
          ppe_d = stat_new_q[`EE_STAT_PPE_BIT];
          bp_d = stat_new_q[`EE_STAT_BP_HI:`EE_STAT_BP_LO];
        end
      end
      pend_prog_d = 1'b0;
      pend_stat_d = 1'b0;
    end else begin
      if (rise_act) begin
        rx_d = rx_byte[6:0];
        bit_d = bit_q + 1'b1;
      end
      if (byte_done) begin
        unique case (state_q)
          ee_spi_pkg::st_op: begin
            state_d = ee_spi_pkg::st_ignore;
            if (rx_byte == `EE_OP_READ_STATUS) begin
              state_d = ee_spi_pkg::st_stat_out;
            end else if (!busy) begin
              unique case (rx_byte)
                `EE_OP_WREN: wel_d = 1'b1;
                `EE_OP_WRDI: wel_d = 1'b0;
                `EE_OP_WRSR: state_d = ee_spi_pkg::st_stat_in;
                `EE_OP_READ, `EE_OP_WRITE: begin
                  state_d = ee_spi_pkg::st_addr;
                  addr_cnt_d = 1'b0;
                  op_wr_d = (rx_byte == `EE_OP_WRITE);
                end
                default: state_d = ee_spi_pkg::st_ignore;
              endcase
            end
          end
          ee_spi_pkg::st_addr: begin
            if (!addr_cnt_q) begin
              addr_d[15:8] = rx_byte;
              addr_cnt_d = 1'b1;
            end else begin
              addr_d[7:0] = rx_byte;
              state_d = op_wr_q ? ee_spi_pkg::st_wr_data :
                                  ee_spi_pkg::st_rd_data;
            end
          end
          ee_spi_pkg::st_wr_data: begin
            if (wel_q) begin
              req_d.wr = 1'b1;
              req_d.addr = addr_q;
              req_d.data = rx_byte;
              // Page roll-over: only the low address bits advance
              addr_d[`EE_PAGE_LO_W-1:0] =
                addr_q[`EE_PAGE_LO_W-1:0] + 1'b1;
              pend_prog_d = 1'b1;
            end
          end
          ee_spi_pkg::st_stat_in: begin
            state_d = ee_spi_pkg::st_ignore;
            // Pin high leaves only latch-based protection
            if (wel_q && !hw_protect) begin
              stat_new_d = rx_byte;
              pend_stat_d = 1'b1;
              pend_prog_d = 1'b1;
            end
          end
          default: ;
        endcase
      end
      if (fall_act && out_state) begin
        // Load at byte boundary, otherwise shift out the next bit
        if (bit_q == `EE_FIRST_BIT) begin
          if (state_q == ee_spi_pkg::st_stat_out) begin
            tx_d = stat_byte;
          end else begin
            tx_d = rd_data;
            addr_d = addr_q + 1'b1;
          end
        end else begin
          tx_d = {tx_q[6:0], 1'b0};
        end
      end
    end
    req_d.addr = req_d.wr ? req_d.addr : addr_q;
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= ee_spi_pkg::st_op;
      sck_prev_q <= 1'b0;
      cs_prev_q <= 1'b1;
      bit_q <= `EE_FIRST_BIT;
      rx_q <= '0;
      tx_q <= 8'h00;
      addr_cnt_q <= 1'b0;
      op_wr_q <= 1'b0;
      addr_q <= 16'h0000;
      wel_q <= 1'b0;
      ppe_q <= 1'b0;
      bp_q <= 2'h0;
      stat_new_q <= 8'h00;
      pend_stat_q <= 1'b0;
      pend_prog_q <= 1'b0;
      prog_cnt_q <= '0;
      req_q <= '0;
    end else begin
      state_q <= state_d;
      sck_prev_q <= sck_prev_d;
      cs_prev_q <= cs_prev_d;
      bit_q <= bit_d;
      rx_q <= rx_d;
      tx_q <= tx_d;
      addr_cnt_q <= addr_cnt_d;
      op_wr_q <= op_wr_d;
      addr_q <= addr_d;
      wel_q <= wel_d;
      ppe_q <= ppe_d;
      bp_q <= bp_d;
      stat_new_q <= stat_new_d;
      pend_stat_q <= pend_stat_d;
      pend_prog_q <= pend_prog_d;
      prog_cnt_q <= prog_cnt_d;
      req_q <= req_d;
    end
  end

  assign so = tx_q[7];
  // Released while deselected, paused, or not in an output phase
  assign so_oe_n = !(active && out_state);
  assign mem_req = req_q;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  AST_SI_SAMPLED_ON_RISE: assert property (
    rise_act && !pins_s.cs_n |=> rx_q[0] == $past(pins_s.si))
    else $error("SI not captured on rising clock");

  AST_SO_CHANGES_ON_FALL: assert property (
    $changed(so) |-> $past(fall_act))
    else $error("SO changed outside a falling clock edge");

  AST_BIT_COUNT_ONLY_ON_CLOCK: assert property (
    $changed(bit_q) |-> $past(rise_act) || $past(pins_s.cs_n))
    else $error("Bit count moved without a serial clock edge");

  AST_CS_HIGH_RELEASES_SO: assert property (
    pins_s.cs_n |-> so_oe_n)
    else $error("SO driven while deselected");

  AST_CS_RISE_ENDS_SESSION: assert property (
    cs_rise |=> state_q == ee_spi_pkg::st_op && bit_q == `EE_FIRST_BIT)
    else $error("Session not closed on chip select rise");

  AST_PIN_HIGH_ALLOWS_STATUS: assert property (
    byte_done && state_q == ee_spi_pkg::st_stat_in && wel_q &&
    pins_s.wp_n |=> pend_stat_q)
    else $error("Status write blocked with protect pin high");

  AST_PIN_LOW_BLOCKS_STATUS: assert property (
    $rose(pend_stat_q) |-> !$past(ppe_q && !pins_s.wp_n))
    else $error("Status write accepted under pin protection");

  AST_PAUSE_FREEZES_SHIFT: assert property (
    !pins_s.hold_n && !pins_s.cs_n ##1 !pins_s.cs_n |->
    $stable(bit_q) && $stable(rx_q) && $stable(tx_q))
    else $error("Shift state moved while paused");

  AST_PAUSE_RELEASES_SO: assert property (
    !pins_s.hold_n |-> so_oe_n)
    else $error("SO driven while paused");

  AST_PROG_TIMER_START: assert property (
    cs_rise && pend_prog_q |=> prog_cnt_q == `EE_PROG_W'(PROG_CYCLES)
    ##1 prog_cnt_q == `EE_PROG_W'(PROG_CYCLES - 1))
    else $error("Programming cycle not started on chip select rise");

  AST_PROTECT_GATED: assert property (
    !ppe_q && byte_done && state_q == ee_spi_pkg::st_stat_in &&
    wel_q |=> pend_stat_q)
    else $error("Pin protected without the enable bit");

  AST_BUSY_IGNORES_OPCODES: assert property (
    busy && byte_done && state_q == ee_spi_pkg::st_op &&
    rx_byte != `EE_OP_READ_STATUS |=> state_q == ee_spi_pkg::st_ignore)
    else $error("Opcode accepted during programming");

  AST_MSB_FIRST_SHIFT: assert property (
    fall_act && out_state && bit_q != `EE_FIRST_BIT |=>
    so == $past(tx_q[6]))
    else $error("Output not shifted MSB first");

  COV_STATUS_READ_BUSY: cover property (
    byte_done && state_q == ee_spi_pkg::st_op && busy &&
    rx_byte == `EE_OP_READ_STATUS);
  COV_WRITE_STARTS_PROG: cover property (cs_rise && pend_prog_q);
  COV_PAUSE_IN_READ: cover property (
    state_q == ee_spi_pkg::st_rd_data && !pins_s.hold_n);
  COV_STATUS_REJECTED: cover property (
    byte_done && state_q == ee_spi_pkg::st_stat_in && hw_protect);

endmodule

// ===== tb/ee_host_model.sv
// Host SPI controller model driving the link in mode (0,0) or (1,1)
module ee_host_model (
  input wire logic core_clk,
  input wire logic so,
  input wire logic so_oe_n,
  output logic sck,
  output logic cs_n,
  output logic si,
  output logic hold_n
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HALF = 4;
  logic line;
  logic oe_seen;
  bit cpol;
  // A released output reads as the inverse of its last value
  assign line = so_oe_n ? ~so : so;
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
    hold_n = 1'b1;
    oe_seen = 1'b0;
    cpol = 1'b0;
  end
  // Idle clock level: low for mode (0,0), high for mode (1,1)
  task automatic set_mode(input bit m);
    cpol = m;
    sck = m;
    wait_n(HALF);
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic start();
    wait_n(1);
    cs_n = 1'b0;
    wait_n(HALF);
  endtask
  task automatic stop();
    wait_n(HALF);
    cs_n = 1'b1;
    wait_n(3 * HALF);
  endtask
  // Pause taken with the clock low; a stray clock pulse must be ignored
  // Pause is only used in mode (0,0)
  task automatic xfer(input logic [7:0] tx, input bit pz,
    output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      si = tx[i];
      if (cpol) begin
        sck = 1'b0;
      end
      wait_n(HALF);
      sck = 1'b1;
      wait_n(HALF);
      rx[i] = line;
      if (!cpol) begin
        sck = 1'b0;
      end
      if (pz && i == 4) begin
        // Let the falling edge pass the synchroniser before pausing
        wait_n(HALF);
        hold_n = 1'b0;
        wait_n(2 * HALF);
        si = ~si;
        sck = 1'b1;
        wait_n(HALF);
        sck = 1'b0;
        oe_seen = so_oe_n;
        wait_n(HALF);
        hold_n = 1'b1;
      end
    end
  endtask
endmodule

// ===== tb/ee_spi_pins_tb.sv
// Self-checking bench for the serial EEPROM pin interface
`include "ee_spi_cfg.svh"
module ee_spi_pins_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PROG = 400;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic wp_n = 1'b1;
  logic sck, cs_n, si, hold_n, so, so_oe_n, busy;
  logic [7:0] rd_data, rx, d0, d1;
  logic [15:0] a;
  ee_spi_pkg::mem_req_s mem_req;
  ee_spi_pkg::mem_req_s wr_q[$];
  int fail_count = 0;
  int n_checks = 0;
  int cyc = 0;
  always #12.5 core_clk = ~core_clk;
  // Memory back end: read data follows the address
  assign rd_data = mem_req.addr[7:0] ^ mem_req.addr[15:8];
  ee_spi_pins #(.PROG_CYCLES(PROG)) dut_u (.core_clk(core_clk),
    .reset_n(reset_n), .sck(sck), .cs_n(cs_n), .si(si),
    .hold_n(hold_n), .wp_n(wp_n), .rd_data(rd_data), .so(so),
    .so_oe_n(so_oe_n), .mem_req(mem_req), .busy(busy));
  ee_host_model host_u (.core_clk(core_clk), .so(so),
    .so_oe_n(so_oe_n), .sck(sck), .cs_n(cs_n), .si(si),
    .hold_n(hold_n));
  task automatic chk8(input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("Error at %0t: expected %h got %h", $time, e, g);
    end
  endtask
  task automatic chk_wr(input ee_spi_pkg::mem_req_s e,
    input ee_spi_pkg::mem_req_s g);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("Error at %0t: expected %h got %h", $time, e, g);
    end
  endtask
  // Sampled mid-cycle so the registered pulse has settled
  always @(negedge core_clk) begin
    if (mem_req.wr === 1'b1) begin
      if (wr_q.size() == 0) chk_wr('0, mem_req);
      else chk_wr(wr_q.pop_front(), mem_req);
    end
  end
  task automatic end_sim();
    $display("Mismatches %0d, checks %0d", fail_count, n_checks);
    if (fail_count == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 60000) begin
      fail_count++;
      end_sim();
    end
  end
  task automatic cmd(input logic [7:0] op);
    host_u.start();
    host_u.xfer(op, 1'b0, rx);
    host_u.stop();
  endtask
  task automatic status(output logic [7:0] s);
    host_u.start();
    host_u.xfer(`EE_OP_READ_STATUS, 1'b0, rx);
    host_u.xfer(8'h00, 1'b0, s);
    host_u.stop();
  endtask
  // Bounded wait; also shows the cycle ends inside its time
  task automatic wait_idle();
    for (int i = 0; i < PROG + 20 && busy !== 1'b0; i++)
      @(negedge core_clk);
    chk8(8'h00, {7'h00, busy});
  endtask
  task automatic wrsr(input logic [7:0] v);
    cmd(`EE_OP_WREN);
    host_u.start();
    host_u.xfer(`EE_OP_WRSR, 1'b0, rx);
    host_u.xfer(v, 1'b0, rx);
    host_u.stop();
    wait_idle();
  endtask
  // Two bytes from ad: the second stays within the page, wrapping at a page end
  task automatic wr2(input logic [15:0] ad, input logic en);
    d0 = 8'($urandom);
    d1 = 8'($urandom);
    if (en) begin
      cmd(`EE_OP_WREN);
      wr_q.push_back({1'b1, ad, d0});
      wr_q.push_back({1'b1, ad[15:7], ad[6:0] + 7'h01, d1});
    end
    host_u.start();
    host_u.xfer(`EE_OP_WRITE, 1'b0, rx);
    host_u.xfer(ad[15:8], 1'b0, rx);
    host_u.xfer(ad[7:0], 1'b0, rx);
    host_u.xfer(d0, 1'b1, rx);
    host_u.xfer(d1, 1'b0, rx);
    host_u.stop();
  endtask
  initial begin
    rx = 8'($urandom(32'he73f39d3));
    repeat (10) @(negedge core_clk);
    reset_n = 1'b1;
    // Power-up wait covers both read and write access
    repeat (`EE_POWER_UP_WRITE_WAIT_MS * 1000000 / `EE_CLK_PERIOD_NS)
      @(negedge core_clk);
    status(rx);
    chk8(8'h00, rx);
    cmd(`EE_OP_WREN);
    status(rx);
    chk8(8'h02, rx);
    cmd(`EE_OP_WRDI);
    status(rx);
    chk8(8'h00, rx);
    wr2(16'h127f, 1'b1);
    chk8(8'h01, {7'h00, busy});
    status(rx);
    chk8(8'h01, rx);
    cmd(`EE_OP_WREN);
    wait_idle();
    status(rx);
    chk8(8'h00, rx);
    wr2(16'h3a10, 1'b0);
    chk8(8'h00, {7'h00, busy});
    a = {8'($urandom), 8'hff};
    host_u.start();
    host_u.xfer(`EE_OP_READ, 1'b0, rx);
    host_u.xfer(a[15:8], 1'b0, rx);
    host_u.xfer(a[7:0], 1'b0, rx);
    host_u.xfer(8'h00, 1'b1, rx);
    chk8(a[7:0] ^ a[15:8], rx);
    chk8(8'h01, {7'h00, host_u.oe_seen});
    a = a + 16'h0001;
    host_u.xfer(8'h00, 1'b0, rx);
    chk8(a[7:0] ^ a[15:8], rx);
    host_u.stop();
    chk8(8'h01, {7'h00, so_oe_n});
    wrsr(8'h8c);
    status(rx);
    chk8(8'h8c, rx);
    wp_n = 1'b0;
    wrsr(8'h00);
    status(rx);
    chk8(8'h8c, rx & 8'hfc);
    wp_n = 1'b1;
    wrsr(8'h00);
    status(rx);
    chk8(8'h00, rx);
    host_u.set_mode(1'b1);
    cmd(`EE_OP_WREN);
    status(rx);
    chk8(8'h02, rx);
    chk8(8'h00, 8'(wr_q.size()));
    end_sim();
  end
endmodule
